// ==== hw/ipm_consts.svh ====
// Constants for the interrupt priority and mask block
`ifndef IPM_CONSTS_SVH
`define IPM_CONSTS_SVH

`define IPM_NUM_SRC      34
`define IPM_NUM_CPU      9
`define IPM_NMI_IDX      9
`define IPM_NUM_NONMASK  10
`define IPM_NUM_PERIPH   21
`define IPM_NUM_EXT      4
`define IPM_LVL_W        3
`define IPM_IDX_W        6
`define IPM_VEC_W        8
`define IPM_LVL_NMI      3'h7
`define IPM_LVL_MAXMASK  3'h6
`define IPM_LVL_OFF      3'h0
`define IPM_MASK_RST     3'h7
`define IPM_VEC_SHIFT    2
`define IPM_XSIZE_W      2

`endif

// ==== hw/ipm_pkg.sv ====
// Types shared by the interrupt priority and mask block
package ipm_pkg;
   typedef logic [2:0] ipm_lvl_t;
   typedef logic [5:0] ipm_idx_t;
   typedef logic [7:0] ipm_vec_t;
   typedef enum logic [1:0] {
      IPM_XFER_1 = 2'h0,
      IPM_XFER_2 = 2'h1,
      IPM_XFER_4 = 2'h2,
      IPM_XFER_4B = 2'h3
   } ipm_xsize_e;
endpackage : ipm_pkg

// ==== hw/ipm_prio_resolve.sv ====
// Combinational priority resolver over all pending sources
`include "ipm_consts.svh"
module ipm_prio_resolve
   import ipm_pkg::*;
(
   // Request state
   input  wire logic [`IPM_NUM_SRC-1:0]   pending,
   input  wire logic [`IPM_NUM_SRC*3-1:0] levelFlat,
   // Winner
   output logic                           bestValid,
   output ipm_lvl_t                       bestLevel,
   output ipm_idx_t                       bestIdx
);
   ipm_lvl_t effLevel [`IPM_NUM_SRC];

   genvar g;
   generate
      for (g = 0; g < `IPM_NUM_SRC; g++) begin : gLevel
         // Sources below the boundary are the CPU traps and the non-maskable pin
         if (g < `IPM_NUM_NONMASK) begin : gFixed
            assign effLevel[g] = `IPM_LVL_NMI;
         end else begin : gProg
            // Level 7 is reserved for non-maskable sources
            assign effLevel[g] = (levelFlat[g*3 +: 3] > `IPM_LVL_MAXMASK) ?
                                 `IPM_LVL_MAXMASK : levelFlat[g*3 +: 3];
         end
      end
   endgenerate

   always_comb begin
      bestValid = 1'b0;
      bestLevel = `IPM_LVL_OFF;
      bestIdx   = '0;
      for (int i = 0; i < `IPM_NUM_SRC; i++) begin
         // Strictly greater keeps the smaller vector on equal levels
         if (pending[i] && effLevel[i] != `IPM_LVL_OFF &&
             (!bestValid || effLevel[i] > bestLevel)) begin
            bestValid = 1'b1;
            bestLevel = effLevel[i];
            bestIdx   = 6'(i);
         end
      end
   end
endmodule : ipm_prio_resolve

// ==== hw/ipm_top.sv ====
// Interrupt controller with priority resolution and CPU mask handling
`include "ipm_consts.svh"
module ipm_top
   import ipm_pkg::*;
(
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      sys_rst,
   // Source events and software clears
   input  wire logic [`IPM_NUM_SRC-1:0]   srcEvent,
   input  wire logic [`IPM_NUM_SRC-1:0]   srcClear,
   input  wire logic [`IPM_NUM_SRC*3-1:0] srcLevelFlat,
   // Fast-transfer setup and software trigger
   input  wire logic [`IPM_NUM_SRC-1:0]   fastEnable,
   input  wire logic [`IPM_NUM_SRC*2-1:0] fastSizeFlat,
   input  wire logic                      swFastTrig,
   input  wire ipm_idx_t                  swFastIdx,
   // CPU side instructions
   input  wire logic                      cpuReady,
   input  wire logic                      setMaskStrobe,
   input  wire ipm_lvl_t                  setMaskValue,
   input  wire logic                      maskAllStrobe,
   // Request presented to the CPU
   output logic                           reqValid,
   output ipm_lvl_t                       reqLevel,
   // Acceptance and vector read
   output logic                           acceptPulse,
   output ipm_vec_t                       acceptVector,
   output ipm_lvl_t                       acceptLevel,
   output ipm_lvl_t                       cpu_interrupt_mask_level,
   // Fast-transfer start
   output logic                           fastStart,
   output logic [2:0]                     fastBytes,
   // Pending flags
   output logic [`IPM_NUM_SRC-1:0]        pending
);
   logic                     bestValid;
   ipm_lvl_t                 bestLevel;
   ipm_idx_t                 bestIdx;
   logic                     maskWrite;
   logic                     passMask;
   logic                     acceptNow;
   logic                     fastSel;
   ipm_xsize_e               fastSize;
   logic [`IPM_NUM_SRC-1:0]  acceptHot;
   logic [`IPM_NUM_SRC-1:0]  swSetHot;
   ipm_lvl_t                 next_mask;

   ipm_prio_resolve uResolve (
      .pending   (pending),
      .levelFlat (srcLevelFlat),
      .bestValid (bestValid),
      .bestLevel (bestLevel),
      .bestIdx   (bestIdx)
   );

   // An instruction in flight owns the mask this cycle, so acceptance waits
   assign maskWrite = setMaskStrobe | maskAllStrobe;
   // Level seven always passes because the mask never exceeds seven
   assign passMask  = bestLevel >= cpu_interrupt_mask_level;
   assign acceptNow = bestValid & passMask & cpuReady & ~maskWrite;
   assign fastSel   = fastEnable[bestIdx];
   assign fastSize  = ipm_xsize_e'(fastSizeFlat[bestIdx*2 +: 2]);

   always_comb begin
      acceptHot = '0;
      swSetHot  = '0;
      if (acceptNow) begin
         acceptHot[bestIdx] = 1'b1;
      end
      if (swFastTrig && swFastIdx < 6'(`IPM_NUM_SRC)) begin
         swSetHot[swFastIdx] = 1'b1;
      end
   end

   // Pending flags: a new event wins over a clear in the same cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pending <= '0;
      end else begin
         pending <= (pending & ~acceptHot & ~srcClear) | srcEvent | swSetHot;
      end
   end

   always_comb begin
      next_mask = cpu_interrupt_mask_level;
      if (setMaskStrobe) begin
         next_mask = setMaskValue;
      end else if (maskAllStrobe) begin
         next_mask = `IPM_MASK_RST;
      end else if (acceptNow && !fastSel) begin
         // Fast transfers leave the mask alone, no routine is entered
         next_mask = (bestLevel == `IPM_LVL_NMI) ? `IPM_LVL_NMI :
                     3'(bestLevel + 3'h1);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cpu_interrupt_mask_level <= `IPM_MASK_RST;
      end else begin
         cpu_interrupt_mask_level <= next_mask;
      end
   end

   // Level of the current winner is presented one cycle later
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reqValid <= 1'b0;
         reqLevel <= `IPM_LVL_OFF;
      end else begin
         reqValid <= bestValid;
         reqLevel <= bestLevel;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         acceptPulse  <= 1'b0;
         acceptVector <= '0;
         acceptLevel  <= `IPM_LVL_OFF;
      end else begin
         acceptPulse <= acceptNow;
         if (acceptNow) begin
            acceptVector <= {2'h0, bestIdx} << `IPM_VEC_SHIFT;
            acceptLevel  <= bestLevel;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fastStart <= 1'b0;
         fastBytes <= 3'h0;
      end else begin
         fastStart <= acceptNow & fastSel;
         if (acceptNow && fastSel) begin
            case (fastSize)
               IPM_XFER_1: fastBytes <= 3'h1;
               IPM_XFER_2: fastBytes <= 3'h2;
               IPM_XFER_4: fastBytes <= 3'h4;
               default:    fastBytes <= 3'h4;
            endcase
         end
      end
   end

   sequence seqTake;
      acceptNow && !fastSel;
   endsequence

   sequence seqRoutine;
      acceptPulse && !fastStart;
   endsequence

   sequence seqFast;
      acceptPulse && fastStart;
   endsequence

   property pMaskRaise;
      @(posedge clock) disable iff (sys_rst)
      seqTake |=> seqRoutine ##0 (cpu_interrupt_mask_level ==
         ((acceptLevel == 3'h7) ? 3'h7 : 3'(acceptLevel + 3'h1)));
   endproperty

   property pFastMove;
      @(posedge clock) disable iff (sys_rst)
      acceptNow && fastSel |=> seqFast ##0
         (fastBytes == 3'h1 || fastBytes == 3'h2 || fastBytes == 3'h4)
         ##0 $stable(cpu_interrupt_mask_level);
   endproperty

   maskRaise_a : assert property (pMaskRaise)
      else $error("mask not raised to accepted level plus one");

   fastMove_a : assert property (pFastMove)
      else $error("fast transfer start or size wrong");

   maskReset_a : assert property (@(posedge clock)
      sys_rst |=> cpu_interrupt_mask_level == 3'h7)
      else $error("mask not seven after reset");

   maskLoad_a : assert property (@(posedge clock) disable iff (sys_rst)
      setMaskStrobe |=> cpu_interrupt_mask_level == $past(setMaskValue) && !acceptPulse)
      else $error("mask operand not loaded");

   maskAll_a : assert property (@(posedge clock) disable iff (sys_rst)
      maskAllStrobe && !setMaskStrobe |=> cpu_interrupt_mask_level == 3'h7)
      else $error("mask-all did not set seven");

   acceptGate_a : assert property (@(posedge clock) disable iff (sys_rst)
      acceptPulse |-> $past(bestLevel) >= $past(cpu_interrupt_mask_level))
      else $error("request accepted below mask");

   vectorFixed_a : assert property (@(posedge clock) disable iff (sys_rst)
      acceptNow |=> acceptVector == {$past(bestIdx), 2'h0} && (!pending[$past(bestIdx)]
         || $past(srcEvent[bestIdx]) || $past(swSetHot[bestIdx])))
      else $error("vector or pending clear wrong");

   holdPending_a : assert property (@(posedge clock) disable iff (sys_rst)
      ##1 (($past(pending) & ~$past(srcClear) & ~$past(acceptHot) & ~pending) == '0))
      else $error("pending request lost");

   presentLevel_a : assert property (@(posedge clock) disable iff (sys_rst)
      bestValid |=> reqValid && reqLevel == $past(bestLevel))
      else $error("winning level not presented");

   swTrigger_a : assert property (@(posedge clock) disable iff (sys_rst)
      swFastTrig && swFastIdx < 6'd34 |=> pending[$past(swFastIdx)])
      else $error("software trigger not pending");

   nonMask_a : assert property (@(posedge clock) disable iff (sys_rst)
      bestValid && bestIdx < 6'd10 |-> bestLevel == 3'h7)
      else $error("non-maskable level not seven");

   maskCap_a : assert property (@(posedge clock) disable iff (sys_rst)
      bestValid && bestIdx >= 6'd10 |-> bestLevel <= 3'h6 && bestLevel != 3'h0)
      else $error("maskable level out of range");

   tieOrder_a : assert property (@(posedge clock) disable iff (sys_rst)
      bestValid && bestIdx > 6'd0 |-> !pending[bestIdx - 6'd1] || bestIdx < 6'd10
         || 3'(srcLevelFlat[(bestIdx-6'd1)*3 +: 3]) < bestLevel
         || srcLevelFlat[(bestIdx-6'd1)*3 +: 3] == 3'h0)
      else $error("equal level did not pick smaller vector");

endmodule : ipm_top

// ==== tb/ipm_cpu_model.sv ====
// CPU-side partner: readiness to take a request, with random stalls
module ipm_cpu_model (
   // Clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // Readiness towards the controller
   output logic      cpuReady
);
   timeunit 1ns;
   timeprecision 1ps;
   // Stalls about one cycle in four so late acceptance is exercised too
   always @(posedge clock) begin
      if (sys_rst) begin
         cpuReady <= 1'b0;
      end else begin
         cpuReady <= ($urandom_range(3) != 0);
      end
   end
endmodule : ipm_cpu_model

// ==== tb/interrupt_priority_masking_tb_top.sv ====
// Self-checking bench for the interrupt priority and mask block
module interrupt_priority_masking_tb_top import ipm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, sys_rst, swFastTrig, cpuReady, setMaskStrobe, maskAllStrobe;
   logic        reqValid, acceptPulse, fastStart;
   logic [33:0] srcEvent, srcClear, fastEnable, pending;
   logic [101:0] srcLevelFlat;
   logic [67:0] fastSizeFlat;
   logic [2:0]  fastBytes;
   ipm_idx_t    swFastIdx;
   ipm_lvl_t    setMaskValue, reqLevel, acceptLevel, maskLevel;
   ipm_vec_t    acceptVector;
   int          fail_count = 0, total_checks = 0, mk, lv[34];
   bit [33:0]   pend;
   bit          hung;

   ipm_top ipm_top_i (.clock(clock), .sys_rst(sys_rst), .srcEvent(srcEvent),
      .srcClear(srcClear), .srcLevelFlat(srcLevelFlat), .fastEnable(fastEnable),
      .fastSizeFlat(fastSizeFlat), .swFastTrig(swFastTrig), .swFastIdx(swFastIdx),
      .cpuReady(cpuReady), .setMaskStrobe(setMaskStrobe), .setMaskValue(setMaskValue),
      .maskAllStrobe(maskAllStrobe), .reqValid(reqValid), .reqLevel(reqLevel),
      .acceptPulse(acceptPulse), .acceptVector(acceptVector), .acceptLevel(acceptLevel),
      .cpu_interrupt_mask_level(maskLevel), .fastStart(fastStart), .fastBytes(fastBytes),
      .pending(pending));
   ipm_cpu_model ipm_cpu_model_i (.clock(clock), .sys_rst(sys_rst), .cpuReady(cpuReady));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic chk(input bit ok, input string what);
      total_checks++;
      if (!ok) begin
         fail_count++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask : chk

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   function automatic int winner();
      int b = -1;
      for (int i = 0; i < 34; i++) begin
         if (pend[i] && lv[i] > 0 && lv[i] >= mk && (b < 0 || lv[i] > lv[b])) begin
            b = i;
         end
      end
      return b;
   endfunction : winner

   // Highest enabled pending level, mask ignored, zero when none
   function automatic int top_level();
      int t = 0;
      for (int i = 0; i < 34; i++) begin
         if (pend[i] && lv[i] > t) begin
            t = lv[i];
         end
      end
      return t;
   endfunction : top_level

   function automatic bit [33:0] sparse();
      return 34'({$urandom, $urandom} & {$urandom, $urandom});
   endfunction : sparse

   // Load a mask, raise a set of events and drain every request the model admits
   task automatic run_case(input int m, input bit [33:0] ev, input int sw);
      int w, sz, n;
      @(posedge clock);
      setMaskStrobe <= (m != 7);
      maskAllStrobe <= (m == 7);
      setMaskValue <= 3'(m);
      @(posedge clock);
      setMaskStrobe <= 1'b0;
      maskAllStrobe <= 1'b0;
      srcEvent <= ev;
      swFastTrig <= 1'b1;
      swFastIdx <= 6'(sw);
      @(posedge clock);
      srcEvent <= '0;
      swFastTrig <= 1'b0;
      mk = m;
      pend |= ev;
      if (sw < 34) pend[sw] = 1'b1;
      @(negedge clock);
      chk(maskLevel === 3'(m), "mask after instruction");
      forever begin
         w = winner();
         if (w < 0) begin
            repeat (8) begin
               @(negedge clock);
               chk(acceptPulse !== 1'b1, "accepted while blocked");
            end
            chk(pending === pend, "blocked request lost");
            chk(reqValid === (top_level() > 0), "request valid wrong");
            chk(reqLevel === 3'(top_level()), "idle level wrong");
            break;
         end
         n = 0;
         do begin
            @(negedge clock);
            n++;
         end while (acceptPulse !== 1'b1 && n < 60);
         if (n >= 60) begin
            // A hang ends the run at once through the closing report
            chk(1'b0, "no acceptance within bound");
            hung = 1'b1;
            return;
         end
         chk(reqValid === 1'b1, "request not presented");
         chk(reqLevel === 3'(lv[w]), "winner level not presented");
         chk(acceptVector === 8'(w * 4), "vector wrong");
         chk(acceptLevel === 3'(lv[w]), "accepted level wrong");
         chk(fastStart === fastEnable[w], "fast start wrong");
         sz = int'(fastSizeFlat[2*w +: 2]);
         if (fastEnable[w]) begin
            chk(fastBytes === (sz == 0 ? 3'h1 : sz == 1 ? 3'h2 : 3'h4), "size wrong");
         end else begin
            mk = (lv[w] == 7) ? 7 : lv[w] + 1;
         end
         chk(maskLevel === 3'(mk), "mask after accept");
         pend[w] = 1'b0;
         chk(pending === pend, "pending after accept");
      end
      // Blocked leftovers are cleared so the next case starts from an empty set
      @(posedge clock);
      srcClear <= pend;
      @(posedge clock);
      srcClear <= '0;
      pend = '0;
      @(negedge clock);
      chk(pending === 34'h0, "leftovers not cleared");
   endtask : run_case

   initial begin
      int raw;
      void'($urandom(32'h6584bc7c));
      sys_rst = 1'b1;
      {swFastTrig, setMaskStrobe, maskAllStrobe, setMaskValue, swFastIdx} = '0;
      srcEvent = '0;
      srcClear = '0;
      fastEnable = 34'({$urandom, $urandom});
      fastSizeFlat = 68'({$urandom, $urandom, $urandom});
      pend = '0;
      for (int i = 0; i < 34; i++) begin
         raw = $urandom_range(7);
         srcLevelFlat[3*i +: 3] = 3'(raw);
         lv[i] = (i < 10) ? 7 : (raw == 7 ? 6 : raw);
      end
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk(maskLevel === 3'h7, "mask after reset");
      chk(pending === 34'h0, "pending after reset");
      run_case(7, sparse() | 34'h200, 40);
      for (int k = 0; k < 40 && !hung; k++) begin
         run_case($urandom_range(7), sparse(), $urandom_range(39));
      end
      complete_run();
   end
endmodule : interrupt_priority_masking_tb_top
